//--- src/fcms_seq.sv
// portable-side cipher mode sequencer: mode handshake, generator loading, segment steering
`timescale 1ns/10ps
module fcms_seq #(
  parameter int DATA_W = 8
) (
  input  wire logic                     clk_i,
  input  wire logic                     nrst_i,
  input  wire logic                     frame_start_i,
  input  wire logic [3:0]               frame_num_i,
  input  wire logic [23:0]              multiframe_num_i,
  input  wire logic [63:0]              cipher_key_i,
  input  wire logic                     duplex_i,
  input  wire logic                     mode_switch_request_prim_i,
  input  wire logic                     cipher_on_confirm_i,
  input  wire logic                     cipher_off_confirm_i,
  input  wire logic                     tail_is_ctrl_i,
  input  wire logic                     ks_valid_i,
  input  wire logic                     ks_bit_i,
  output logic                          ks_ready_o,
  input  wire logic                     rx_valid_i,
  input  wire logic [DATA_W-1:0]        rx_data_i,
  output logic                          rx_ready_o,
  output logic                          out_valid_o,
  input  wire logic                     out_ready_i,
  output logic [DATA_W-1:0]             out_data_o,
  output logic                          ksg_load_o,
  output logic [63:0]                   ksg_key_o,
  output logic [34:0]                   ksg_iv_o,
  output logic [2:0]                    tail_msg_o,
  output logic                          tx_cipher_o,
  output logic                          rx_cipher_o,
  output logic                          rx_discard_o,
  output logic                          mode_encrypt_o,
  output logic                          mode_switch_confirm_prim_o,
  output logic                          disconnect_indication_prim_o
);
  fcms_pkg::fcms_state_e st_q, st_d;
  logic [fcms_pkg::REQ_CNT_W-1:0] nreq_q, nreq_d;
  logic [2:0]  msg_q, msg_d;
  logic        enc_q, enc_d, txc_q, txc_d, rxc_q, rxc_d, disc_q, disc_d;
  logic        cfm_q, cfm_d, rel_q, rel_d, ld_q, ld_d;
  logic [63:0] key_q, key_d;
  logic [34:0] iv_q, iv_d;
  logic [9:0]  bitpos_q, bitpos_d;
  logic        even, pending;
  logic [DATA_W-1:0] ks_sh_q, ks_sh_d;
  logic [$clog2(DATA_W+1)-1:0] ks_n_q, ks_n_d;
  logic        word_ready, ks_in_seg0, ks_use;
  logic        fifo_in_ready, fifo_in_valid, rx_take;
  logic [DATA_W-1:0] fifo_in_data;

  assign even    = !frame_num_i[0];
  assign pending = st_q == fcms_pkg::FCMS_ON_REQ || st_q == fcms_pkg::FCMS_OFF_REQ;

  always_comb begin
    st_d   = st_q;
    nreq_d = nreq_q;
    msg_d  = msg_q;
    enc_d  = enc_q;
    txc_d  = txc_q;
    rxc_d  = rxc_q;
    disc_d = disc_q;
    cfm_d  = 1'b0;
    rel_d  = 1'b0;
    ld_d   = 1'b0;
    key_d  = key_q;
    iv_d   = iv_q;
    if (frame_start_i) begin
      msg_d = fcms_pkg::MSG_NONE;
      case (st_q)
        fcms_pkg::FCMS_CLEAR: begin
          if (mode_switch_request_prim_i && even && duplex_i) begin
            st_d   = fcms_pkg::FCMS_ON_REQ;
            nreq_d = fcms_pkg::REQ_CNT_W'(1);
            msg_d  = fcms_pkg::MSG_ON_RQ;
            disc_d = 1'b1;
          end
        end
        fcms_pkg::FCMS_ON_REQ, fcms_pkg::FCMS_OFF_REQ: begin
          if (even && nreq_q < fcms_pkg::REQ_CNT_W'(fcms_pkg::MAX_REQ)) begin
            nreq_d = nreq_q + 1'b1;
            msg_d  = st_q == fcms_pkg::FCMS_ON_REQ ? fcms_pkg::MSG_ON_RQ : fcms_pkg::MSG_OFF_RQ;
          end else if (even) begin
            st_d   = fcms_pkg::FCMS_RELEASED;
            rel_d  = 1'b1;
            enc_d  = 1'b0;
            txc_d  = 1'b0;
            rxc_d  = 1'b0;
            disc_d = 1'b0;
          end
        end
        fcms_pkg::FCMS_ON_GRANT: begin
          st_d  = fcms_pkg::FCMS_CIPHER;
          msg_d = fcms_pkg::MSG_ON_GR;
          txc_d = 1'b1;
        end
        fcms_pkg::FCMS_CIPHER: begin
          if (mode_switch_request_prim_i && even && duplex_i) begin
            st_d   = fcms_pkg::FCMS_OFF_REQ;
            nreq_d = fcms_pkg::REQ_CNT_W'(1);
            msg_d  = fcms_pkg::MSG_OFF_RQ;
            disc_d = 1'b1;
          end
        end
        fcms_pkg::FCMS_OFF_GRANT: begin
          st_d  = fcms_pkg::FCMS_CLEAR;
          msg_d = fcms_pkg::MSG_OFF_GR;
          txc_d = 1'b0;
          enc_d = 1'b0;
        end
        default: begin
          st_d = st_q;
        end
      endcase
      if (enc_d || st_d == fcms_pkg::FCMS_ON_REQ) begin
        ld_d  = 1'b1;
        key_d = cipher_key_i;
        iv_d  = {{fcms_pkg::IV_PAD_W{1'b0}}, multiframe_num_i, frame_num_i};
      end
    end else if (pending && !even) begin
      // odd frame receive: confirm from the fixed side
      if (st_q == fcms_pkg::FCMS_ON_REQ && cipher_on_confirm_i) begin
        st_d   = fcms_pkg::FCMS_ON_GRANT;
        rxc_d  = 1'b1;
        enc_d  = 1'b1;
        disc_d = 1'b0;
        cfm_d  = 1'b1;
      end else if (st_q == fcms_pkg::FCMS_OFF_REQ && cipher_off_confirm_i) begin
        st_d   = fcms_pkg::FCMS_OFF_GRANT;
        rxc_d  = 1'b0;
        disc_d = 1'b0;
        cfm_d  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q   <= fcms_pkg::FCMS_CLEAR;
      nreq_q <= '0;
      msg_q  <= fcms_pkg::MSG_NONE;
      enc_q  <= 1'b0;
      txc_q  <= 1'b0;
      rxc_q  <= 1'b0;
      disc_q <= 1'b0;
      cfm_q  <= 1'b0;
      rel_q  <= 1'b0;
      ld_q   <= 1'b0;
      key_q  <= '0;
      iv_q   <= '0;
    end else begin
      st_q   <= st_d;
      nreq_q <= nreq_d;
      msg_q  <= msg_d;
      enc_q  <= enc_d;
      txc_q  <= txc_d;
      rxc_q  <= rxc_d;
      disc_q <= disc_d;
      cfm_q  <= cfm_d;
      rel_q  <= rel_d;
      ld_q   <= ld_d;
      key_q  <= key_d;
      iv_q   <= iv_d;
    end
  end

  // key stream: bits 0..359 decrypt receive, 360..719 are taken and dropped; receive skips tail bits unless control
  assign ks_in_seg0 = bitpos_q < 10'(fcms_pkg::SEG_BITS);
  assign ks_use     = ks_in_seg0 && (tail_is_ctrl_i || bitpos_q >= 10'(fcms_pkg::TAIL_KS_BITS));
  assign word_ready = ks_n_q == ($clog2(DATA_W+1))'(DATA_W);
  assign ks_ready_o = !word_ready && bitpos_q < 10'(fcms_pkg::PAIR_BITS);

  always_comb begin
    bitpos_d = bitpos_q;
    ks_sh_d  = ks_sh_q;
    ks_n_d   = ks_n_q;
    if (ld_q) begin
      bitpos_d = '0;
      ks_n_d   = '0;
    end else begin
      if (ks_valid_i && ks_ready_o) begin
        bitpos_d = bitpos_q + 1'b1;
        if (ks_use) begin
          ks_sh_d = {ks_bit_i, ks_sh_q[DATA_W-1:1]};
          ks_n_d  = ks_n_q + 1'b1;
        end
      end
      if (word_ready && rx_valid_i && fifo_in_ready) begin
        ks_n_d = '0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bitpos_q <= 10'(fcms_pkg::PAIR_BITS);
      ks_sh_q  <= '0;
      ks_n_q   <= '0;
    end else begin
      bitpos_q <= bitpos_d;
      ks_sh_q  <= ks_sh_d;
      ks_n_q   <= ks_n_d;
    end
  end

  // clear data passes without key; discarded data is dropped before the buffer
  assign rx_take       = !rxc_q || word_ready;
  assign rx_ready_o    = rx_take && (fifo_in_ready || disc_q);
  assign fifo_in_valid = rx_valid_i && rx_take && !disc_q;
  assign fifo_in_data  = rxc_q ? (rx_data_i ^ ks_sh_q) : rx_data_i;

  fcms_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (fcms_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in_data),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i),
    .out_data_o  (out_data_o)
  );

  assign ksg_load_o                   = ld_q;
  assign ksg_key_o                    = key_q;
  assign ksg_iv_o                     = iv_q;
  assign tail_msg_o                   = msg_q;
  assign tx_cipher_o                  = txc_q;
  assign rx_cipher_o                  = rxc_q;
  assign rx_discard_o                 = disc_q;
  assign mode_encrypt_o               = enc_q;
  assign mode_switch_confirm_prim_o   = cfm_q;
  assign disconnect_indication_prim_o = rel_q;

  property p_req_even;
    @(posedge clk_i) disable iff (!nrst_i)
      $changed(msg_q) && (msg_q == fcms_pkg::MSG_ON_RQ) |-> !$past(frame_num_i[0]);
  endproperty
  a_req_even: assert property (p_req_even) else $error("request outside even frame");

  property p_grant_follows;
    @(posedge clk_i) disable iff (!nrst_i)
      (st_q == fcms_pkg::FCMS_ON_GRANT) && frame_start_i |=> tx_cipher_o && msg_q == fcms_pkg::MSG_ON_GR;
  endproperty
  a_grant_follows: assert property (p_grant_follows) else $error("grant frame not encrypted");

  property p_release;
    @(posedge clk_i) disable iff (!nrst_i)
      disconnect_indication_prim_o |-> st_q == fcms_pkg::FCMS_RELEASED && !mode_encrypt_o;
  endproperty
  a_release: assert property (p_release) else $error("release with wrong state");

  property p_max_req;
    @(posedge clk_i) disable iff (!nrst_i)
      nreq_q <= fcms_pkg::REQ_CNT_W'(fcms_pkg::MAX_REQ);
  endproperty
  a_max_req: assert property (p_max_req) else $error("too many requests");

  property p_iv_pad;
    @(posedge clk_i) disable iff (!nrst_i)
      ksg_load_o |-> ksg_iv_o[34:28] == 7'h00 && ksg_iv_o[3:0] == $past(frame_num_i);
  endproperty
  a_iv_pad: assert property (p_iv_pad) else $error("initial value malformed");

  property p_start_clear;
    @(posedge clk_i) $rose(nrst_i) |-> !mode_encrypt_o && !tx_cipher_o;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("not clear after reset");

  property p_confirm_rx;
    @(posedge clk_i) disable iff (!nrst_i)
      mode_switch_confirm_prim_o && st_q == fcms_pkg::FCMS_ON_GRANT |-> rx_cipher_o && !rx_discard_o;
  endproperty
  a_confirm_rx: assert property (p_confirm_rx) else $error("confirm frame not decrypted");

  property p_stop_rx;
    @(posedge clk_i) disable iff (!nrst_i)
      mode_switch_confirm_prim_o && st_q == fcms_pkg::FCMS_OFF_GRANT |-> !rx_cipher_o;
  endproperty
  a_stop_rx: assert property (p_stop_rx) else $error("stop confirm frame decrypted");

  c_start: cover property (@(posedge clk_i) st_q == fcms_pkg::FCMS_ON_GRANT ##[1:1000] st_q == fcms_pkg::FCMS_CIPHER);
  c_stop: cover property (@(posedge clk_i) st_q == fcms_pkg::FCMS_OFF_GRANT);
  c_rel: cover property (@(posedge clk_i) disconnect_indication_prim_o);
endmodule

//--- src/fcms_pkg.sv
// shared constants and types of the frame cipher mode sequencer
package fcms_pkg;
  localparam int CK_W          = 64;
  localparam int IV_W          = 35;
  localparam int IV_FN_LSB     = 0;
  localparam int IV_FN_W       = 4;
  localparam int IV_MFN_LSB    = 4;
  localparam int IV_MFN_W      = 24;
  localparam int IV_PAD_W      = 7;
  localparam int SEG_BITS      = 360;
  localparam int PAIR_BITS     = 720;
  localparam int TAIL_KS_BITS  = 40;
  localparam int MAX_REQ       = 5;
  localparam int REQ_CNT_W     = 3;
  localparam int FIFO_DEPTH    = 8;
  localparam logic [2:0] MSG_NONE  = 3'h0;
  localparam logic [2:0] MSG_ON_RQ = 3'h1;
  localparam logic [2:0] MSG_ON_GR = 3'h2;
  localparam logic [2:0] MSG_OFF_RQ = 3'h3;
  localparam logic [2:0] MSG_OFF_GR = 3'h4;
  typedef enum logic [2:0] {
    FCMS_CLEAR    = 3'b000,
    FCMS_ON_REQ   = 3'b001,
    FCMS_ON_GRANT = 3'b010,
    FCMS_CIPHER   = 3'b011,
    FCMS_OFF_REQ  = 3'b100,
    FCMS_OFF_GRANT = 3'b101,
    FCMS_RELEASED = 3'b110
  } fcms_state_e;
endpackage

//--- src/fcms_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module fcms_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  assign push        = in_valid_i && (cnt_q != (AW+1)'(DEPTH));
  assign pop         = out_valid_o && out_ready_i;
  assign in_ready_o  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_q != '0;
  assign out_data_o  = mem[rd_q];

  always_comb begin
    wr_d  = push ? AW'((wr_q + 1'b1) % DEPTH) : wr_q;
    rd_d  = pop ? AW'((rd_q + 1'b1) % DEPTH) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end
endmodule

//--- tb/fcms_fixed_side_model.sv
// fixed-side partner model: frame timing, serial key stream and mode confirms
`timescale 1ns/10ps
module fcms_fixed_side_model #(
  parameter int FRAME_LEN = 1000
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        answer_en_i,
  input  wire logic [2:0]  tail_msg_i,
  input  wire logic        ks_ready_i,
  output logic             frame_start_o,
  output logic [3:0]       frame_num_o,
  output logic [23:0]      multiframe_num_o,
  output logic             ks_valid_o,
  output logic             ks_bit_o,
  output logic             on_confirm_o,
  output logic             off_confirm_o
);
  int         cyc;
  logic [2:0] heard;
  logic [7:0] lfsr;
  logic [3:0] win;
  // one shared stream: our transmit uses the first segment, our receive the second
  assign ks_bit_o = lfsr[0];
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cyc              <= 0;
      frame_start_o    <= 1'b0;
      frame_num_o      <= 4'hF;
      multiframe_num_o <= 24'h00_0A3B;
      ks_valid_o       <= 1'b0;
      lfsr             <= 8'h5B;
      heard            <= fcms_pkg::MSG_NONE;
      win              <= 4'h0;
      on_confirm_o     <= 1'b0;
      off_confirm_o    <= 1'b0;
    end else begin
      cyc           <= (cyc == FRAME_LEN - 1) ? 0 : cyc + 1;
      frame_start_o <= (cyc == FRAME_LEN - 1);
      if (cyc == FRAME_LEN - 1) begin
        frame_num_o <= frame_num_o + 4'h1;
        if (frame_num_o == 4'hF) begin
          multiframe_num_o <= multiframe_num_o + 24'h00_0001;
        end
      end
      ks_valid_o <= 1'b1;
      // bits advance only when taken, so a frame's pair stays one unbroken run
      if (ks_valid_o && ks_ready_i) begin
        lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      end
      // start request and stop grant arrive in clear, start grant and stop request enciphered; receive data before the grant would be dropped here
      if (cyc == 3 && !frame_num_o[0]) begin
        heard <= tail_msg_i;
      end
      // confirm window spans six odd frames; past it we stop answering and would release
      if (cyc == 5 && frame_num_o[0]) begin
        if (heard == fcms_pkg::MSG_ON_RQ || heard == fcms_pkg::MSG_OFF_RQ) begin
          win <= (win == 4'hF) ? win : win + 4'h1;
        end else begin
          win <= 4'h0;
        end
      end
      // answer once, at cycle 5 of the odd frame, clear of the frame start
      on_confirm_o  <= (cyc == 5) && frame_num_o[0] && answer_en_i && (win < 4'h6) &&
                       (heard == fcms_pkg::MSG_ON_RQ);
      off_confirm_o <= (cyc == 5) && frame_num_o[0] && answer_en_i && (win < 4'h6) &&
                       (heard == fcms_pkg::MSG_OFF_RQ);
    end
  end
endmodule

//--- tb/frame_cipher_mode_sequencer_tb_top.sv
// self-checking bench for the portable-side cipher mode sequencer
`timescale 1ns/10ps
module frame_cipher_mode_sequencer_tb_top;
  localparam int FL = 1000;
  logic        clk, nrst, fs, duplex, req, on_cf, off_cf, ctrl, ks_v, ks_b, ks_r, rx_v, rx_r, out_v, out_r, answer;
  logic        load, tx_c, rx_c, drop, mode, cfm_p, disc_p;
  logic [3:0]  fn, fn_seen;
  logic [23:0] mfn, mfn_seen;
  logic [7:0]  rx_d, out_d;
  logic [63:0] key, key_o;
  logic [34:0] iv;
  logic [2:0]  tail;
  int          fails, checked, cfm_cnt, disc_cnt, ks_cnt, ks_last;

  fcms_seq #(.DATA_W(8)) fcms_seq_i (
    .clk_i(clk), .nrst_i(nrst), .frame_start_i(fs), .frame_num_i(fn), .multiframe_num_i(mfn),
    .cipher_key_i(key), .duplex_i(duplex), .mode_switch_request_prim_i(req),
    .cipher_on_confirm_i(on_cf), .cipher_off_confirm_i(off_cf), .tail_is_ctrl_i(ctrl),
    .ks_valid_i(ks_v), .ks_bit_i(ks_b), .ks_ready_o(ks_r), .rx_valid_i(rx_v), .rx_data_i(rx_d),
    .rx_ready_o(rx_r), .out_valid_o(out_v), .out_ready_i(out_r), .out_data_o(out_d), .ksg_load_o(load),
    .ksg_key_o(key_o), .ksg_iv_o(iv), .tail_msg_o(tail), .tx_cipher_o(tx_c), .rx_cipher_o(rx_c),
    .rx_discard_o(drop), .mode_encrypt_o(mode), .mode_switch_confirm_prim_o(cfm_p),
    .disconnect_indication_prim_o(disc_p)
  );
  fcms_fixed_side_model #(.FRAME_LEN(FL)) fcms_fixed_side_model_i (
    .clk_i(clk), .nrst_i(nrst), .answer_en_i(answer), .tail_msg_i(tail), .ks_ready_i(ks_r),
    .frame_start_o(fs), .frame_num_o(fn), .multiframe_num_o(mfn), .ks_valid_o(ks_v), .ks_bit_o(ks_b),
    .on_confirm_o(on_cf), .off_confirm_o(off_cf)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // event counters and a steady receive stream that advances on each accepted word
  always @(posedge clk) begin
    if (cfm_p === 1'b1) cfm_cnt++;
    if (disc_p === 1'b1) disc_cnt++;
    if (rx_v === 1'b1 && rx_r === 1'b1) rx_d <= rx_d + 8'h01;
    if (fs === 1'b1) begin
      ks_last <= ks_cnt;
      ks_cnt  <= 0;
    end else if (ks_v === 1'b1 && ks_r === 1'b1) begin
      ks_cnt <= ks_cnt + 1;
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // returns at the edge that takes the frame start of the wanted parity
  task automatic wait_frame(input logic par);
    for (int k = 0; k < 4 * FL; k++) begin
      @(posedge clk);
      if (fs === 1'b1 && fn[0] === par) begin
        fn_seen  = fn;
        mfn_seen = mfn;
        return;
      end
    end
    fails++;
    $display("BAD frame wait timed out");
    give_verdict();
  endtask

  task automatic wait_cfm(input int was);
    for (int k = 0; k < 4 * FL; k++) begin
      step(1);
      if (cfm_cnt > was) return;
    end
    fails++;
    $display("BAD confirm wait timed out");
    give_verdict();
  endtask

  task automatic t_reset();
    chk("mode", 0, {mode, tx_c, rx_c, drop});
    chk("tail", fcms_pkg::MSG_NONE, tail);
    chk("load", 0, load);
    $display("test reset done");
  endtask

  task automatic t_refuse();
    @(posedge clk);
    duplex <= 1'b0;
    req    <= 1'b1;
    wait_frame(1'b0);
    #1;
    chk("tail simplex", fcms_pkg::MSG_NONE, tail);
    @(posedge clk);
    duplex <= 1'b1;
    wait_frame(1'b1);
    req <= 1'b0;
    #1;
    chk("tail odd", fcms_pkg::MSG_NONE, tail);
    $display("test refuse done");
  endtask

  task automatic t_fifo();
    int n;
    n = 0;
    @(posedge clk);
    rx_v <= 1'b1;
    for (int k = 0; k < 20; k++) begin
      @(posedge clk);
      if (rx_r === 1'b1) n++;
    end
    chk("fill", fcms_pkg::FIFO_DEPTH, n);
    rx_v  <= 1'b0;
    out_r <= 1'b1;
    n = 0;
    for (int k = 0; k < 20; k++) begin
      @(posedge clk);
      if (out_v === 1'b1) begin
        chk("clear word", 8'h30 + n, out_d);
        n++;
      end
    end
    chk("drain", fcms_pkg::FIFO_DEPTH, n);
    rx_v <= 1'b1;
    $display("test fifo done");
  endtask

  task automatic t_switch(input logic on);
    int was;
    @(posedge clk);
    req <= 1'b1;
    wait_frame(1'b0);
    req <= 1'b0;
    was = cfm_cnt;
    // load pulse stands only in the cycle after the frame start
    #1;
    chk("req msg", on ? fcms_pkg::MSG_ON_RQ : fcms_pkg::MSG_OFF_RQ, tail);
    chk("drop", 1, drop);
    if (on) begin
      chk("load", 1, load);
      chk("key", key, key_o);
      chk("iv", {7'h00, mfn_seen, fn_seen}, iv);
    end
    wait_cfm(was);
    chk("after confirm", {1'b1, on, 1'b0, !on}, {mode, rx_c, drop, tx_c});
    wait_frame(1'b0);
    #1;
    chk("grant msg", on ? fcms_pkg::MSG_ON_GR : fcms_pkg::MSG_OFF_GR, tail);
    chk("both ways", {on, on}, {tx_c, rx_c});
    wait_frame(1'b1);
    #1;
    chk("reload", on, load);
    if (on) begin
      chk("pair bits", fcms_pkg::PAIR_BITS, ks_last);
      chk("iv next", {7'h00, mfn_seen, fn_seen}, iv);
    end
    $display("test switch %0d done", on);
  endtask

  task automatic t_silent();
    int was, n;
    n = 0;
    @(posedge clk);
    answer <= 1'b0;
    req    <= 1'b1;
    wait_frame(1'b0);
    req <= 1'b0;
    was = disc_cnt;
    for (int f = 0; f < 6; f++) begin
      if (f > 0) wait_frame(1'b0);
      #1;
      if (tail === fcms_pkg::MSG_ON_RQ) n++;
    end
    chk("requests", fcms_pkg::MAX_REQ, n);
    step(2);
    chk("disconnect", 1, disc_cnt - was);
    @(posedge clk);
    req <= 1'b1;
    wait_frame(1'b0);
    req <= 1'b0;
    #1;
    chk("released", {3'h0, 1'b0}, {tail, mode});
    $display("test silent done");
  endtask

  initial begin
    {nrst, duplex, req, ctrl, rx_v, out_r, answer} = 7'b0100001;
    rx_d     = 8'h30;
    key      = 64'hA5C3_1E7F_0B92_D468;
    fails    = 0;
    checked  = 0;
    cfm_cnt  = 0;
    disc_cnt = 0;
    ks_cnt   = 0;
    ks_last  = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    step(1);
    t_reset();
    t_refuse();
    t_fifo();
    t_switch(1'b1);
    t_switch(1'b0);
    t_silent();
    give_verdict();
  end
endmodule
